/* File: verilog/nvm_protect_pkg.sv */
/*
  Constants, types and decode helpers for the protection configuration block.
  Assumes a 32-bit AXI4-Lite bus with 24-bit byte addresses; each printed
  offset is a word index and the byte address is four times it.
*/
`default_nettype none
package nvm_protect_pkg;
  localparam int          AXI_ADDR_W = 24;
  localparam int          WORD_W     = 16;
  localparam int          N_WORDS    = 3;
  localparam int          N_BLOCKS   = 4;

  // Word indices as printed; byte address is the index times four
  localparam logic [21:0] IDX_WP  = 22'h300006;
  localparam logic [21:0] IDX_CP  = 22'h300008;
  localparam logic [21:0] IDX_RP  = 22'h30000a;
  localparam logic [21:0] IDX_REV = 22'h3ffffc;
  localparam logic [21:0] IDX_DEV = 22'h3ffffe;

  localparam int LVP_BIT   = 13;
  localparam int SCAN_BIT  = 12;
  localparam int EE_BIT    = 10;
  localparam int BOOT_BIT  = 9;
  localparam int CFG_BIT   = 8;
  localparam int CPD_BIT   = 1;
  localparam int CP_BIT    = 0;
  localparam int BTR_BIT   = 9;
  localparam int MAJ_LSB   = 6;
  localparam int FAM_LSB   = 12;

  // Implemented bits; erased (unprogrammed) state is all implemented bits high
  localparam logic [15:0] WP_MASK = 16'h370f;
  localparam logic [15:0] CP_MASK = 16'h0003;
  localparam logic [15:0] RP_MASK = 16'h020f;
  localparam logic [47:0] ERASED  = {RP_MASK, CP_MASK, WP_MASK};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    A_WP = 3'h0, A_CP = 3'h1, A_RP = 3'h2, A_REV = 3'h3, A_DEV = 3'h4, A_NONE = 3'h7
  } addr_code_t;

  typedef enum logic [2:0] {
    RG_EEPROM = 3'h0, RG_BOOT = 3'h1, RG_CONFIG = 3'h2, RG_OTHER = 3'h3,
    RG_BLOCK0 = 3'h4, RG_BLOCK1 = 3'h5, RG_BLOCK2 = 3'h6, RG_BLOCK3 = 3'h7
  } region_t;

  // Gray sequence along the load path
  typedef enum logic [2:0] {
    ST_LOAD0 = 3'h0, ST_LOAD1 = 3'h1, ST_LOAD2 = 3'h3, ST_LOAD3 = 3'h2, ST_READY = 3'h6
  } load_state_t;

  function automatic addr_code_t decodeAddr(input logic [AXI_ADDR_W-1:0] a);
    if (a == {IDX_WP, 2'h0})       decodeAddr = A_WP;
    else if (a == {IDX_CP, 2'h0})  decodeAddr = A_CP;
    else if (a == {IDX_RP, 2'h0})  decodeAddr = A_RP;
    else if (a == {IDX_REV, 2'h0}) decodeAddr = A_REV;
    else if (a == {IDX_DEV, 2'h0}) decodeAddr = A_DEV;
    else                           decodeAddr = A_NONE;
  endfunction

  function automatic logic [15:0] maskOf(input logic [1:0] idx);
    case (idx)
      2'h0:    maskOf = WP_MASK;
      2'h1:    maskOf = CP_MASK;
      2'h2:    maskOf = RP_MASK;
      default: maskOf = 16'h0000;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: verilog/config_word_store.sv */
/*
  Small word store standing in for the non-volatile configuration words.
  Assumes one writer and one reader per cycle; read data are registered.
*/
`default_nettype none
module config_word_store #(
  parameter int                   WORDS  = 3,
  parameter int                   W      = 16,
  parameter logic [WORDS*W-1:0]   ERASE  = '1
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     wrEn,
  input  wire logic [1:0]               wrIdx,
  input  wire logic [W-1:0]             wrData,
  input  wire logic [1:0]               rdIdx,
  output logic      [W-1:0]             rdData
);
  if (WORDS < 1 || WORDS > 4 || W < 1) begin : g_check
    $error("config_word_store: WORDS must be 1..4 and W positive");
  end

  logic [W-1:0] cells [WORDS];

  // Reset models the erased array; a real part keeps contents across resets
  for (genvar i = 0; i < WORDS; i++) begin : g_cell
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cells[i] <= ERASE[i*W +: W];
      end else if (wrEn && wrIdx == 2'(i)) begin
        cells[i] <= wrData;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= '0;
    end else if (int'(rdIdx) < WORDS) begin
      rdData <= cells[rdIdx];
    end else begin
      rdData <= '0;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/nvm_protection_config.sv */
/*
  Protection configuration decoder with AXI4-Lite register access.
  Assumes a programmer port and memory controller on the same clock, and
  that requests are only meaningful once cfgReady is high.
*/
`default_nettype none
module nvm_protection_config #(
  parameter logic [15:0] PART_ID     = 16'h5a3c, // Arbitrary value
  parameter logic [3:0]  FAMILY_CODE = 4'h6,     // Arbitrary value
  parameter logic [5:0]  MAJOR_REV   = 6'h01,    // Arbitrary value
  parameter logic [5:0]  MINOR_REV   = 6'h02     // Arbitrary value
) (
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [nvm_protect_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                        awprot,
  input  wire logic                              wvalid,
  output logic                                   wready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  output logic                                   bvalid,
  input  wire logic                              bready,
  output logic      [1:0]                        bresp,
  input  wire logic                              arvalid,
  output logic                                   arready,
  input  wire logic [nvm_protect_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic [2:0]                        arprot,
  output logic                                   rvalid,
  input  wire logic                              rready,
  output logic      [31:0]                       rdata,
  output logic      [1:0]                        rresp,
  input  wire logic                              lvpSession,
  input  wire logic                              progWrEn,
  input  wire logic [1:0]                        progWrIndex,
  input  wire logic [15:0]                       progWrData,
  input  wire logic                              masterClearPinEnable,
  input  wire logic                              scannerModuleDisable,
  input  wire logic                              memWrReq,
  input  wire nvm_protect_pkg::region_t          memWrRegion,
  input  wire logic                              tblRdReq,
  input  wire nvm_protect_pkg::region_t          tblRdTarget,
  input  wire nvm_protect_pkg::region_t          tblRdSource,
  output logic                                   cfgReady,
  output logic                                   masterClearActive,
  output logic                                   hvProgRequired,
  output logic                                   scannerRun,
  output logic                                   dataCodeProtected,
  output logic                                   progCodeProtected,
  output logic                                   memWrGrant,
  output logic                                   memWrDeny,
  output logic                                   tblRdGrant,
  output logic                                   tblRdDeny
);
  import nvm_protect_pkg::*;

  load_state_t  state;
  logic [15:0]  wpWord;
  logic [15:0]  cpWord;
  logic [15:0]  rpWord;
  logic [15:0]  storeRd;
  logic [1:0]   rdIdx;
  logic         awHeld;
  logic         wHeld;
  logic [23:0]  awAddrQ;
  logic [15:0]  wDataQ;
  logic [1:0]   wStrbQ;
  addr_code_t   awCode;
  logic         doWrite;
  logic         busOk;
  logic [15:0]  busBase;
  logic [15:0]  busMask;
  logic [15:0]  busNew;
  logic [15:0]  progNew;
  logic         stWrEn;
  logic [1:0]   stWrIdx;
  logic [15:0]  stWrData;
  logic         stReady;

  function automatic logic wrAllowed(input region_t rg, input logic [15:0] wp);
    case (rg)
      RG_EEPROM: wrAllowed = wp[EE_BIT];
      RG_BOOT:   wrAllowed = wp[BOOT_BIT];
      RG_CONFIG: wrAllowed = wp[CFG_BIT];
      RG_OTHER:  wrAllowed = 1'b1;
      default:   wrAllowed = wp[rg[1:0]];
    endcase
  endfunction

  // Reads from inside the target block are refused only before the words are loaded
  function automatic logic rdAllowed(input region_t tg, input region_t src,
                                     input logic [15:0] rp);
    if (tg == src)                 rdAllowed = 1'b1;
    else if (tg == RG_BOOT)        rdAllowed = rp[BTR_BIT];
    else if (tg[2])                rdAllowed = rp[tg[1:0]];
    else                           rdAllowed = 1'b1;
  endfunction

  assign stReady = (state == ST_READY);

  // ****************************************************************
  // Load of the configuration words after reset
  // ****************************************************************
  always_comb begin
    case (state)
      ST_LOAD0: rdIdx = 2'h0;
      ST_LOAD1: rdIdx = 2'h1;
      default:  rdIdx = 2'h2;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_LOAD0;
    end else begin
      case (state)
        ST_LOAD0: state <= ST_LOAD1;
        ST_LOAD1: state <= ST_LOAD2;
        ST_LOAD2: state <= ST_LOAD3;
        ST_LOAD3: state <= ST_READY;
        ST_READY: state <= ST_READY;
        default:  state <= ST_LOAD0;
      endcase
    end
  end

  config_word_store #(
    .WORDS (N_WORDS),
    .W     (WORD_W),
    .ERASE (ERASED)
  ) u_store (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .wrEn    (stWrEn),
    .wrIdx   (stWrIdx),
    .wrData  (stWrData),
    .rdIdx   (rdIdx),
    .rdData  (storeRd)
  );

  // ****************************************************************
  // Write merge and protection of the configuration words
  // ****************************************************************
  assign awCode  = decodeAddr(awAddrQ);
  assign doWrite = awHeld && wHeld && !bvalid && !progWrEn;

  always_comb begin
    busMask = {{8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
    case (awCode)
      A_WP:    busBase = wpWord;
      A_RP:    busBase = rpWord;
      default: busBase = 16'h0000;
    endcase
    busMask = busMask & maskOf(awCode[1:0]);
    busNew  = (busBase & ~busMask) | (wDataQ & busMask);
    if (awCode == A_WP && lvpSession && wpWord[LVP_BIT]) begin
      busNew[LVP_BIT] = 1'b1;
    end
    // Code-protect word is read-only to software
    busOk = (awCode == A_WP || awCode == A_RP) && wpWord[CFG_BIT];
    progNew = progWrData & maskOf(progWrIndex);
    if (progWrIndex == 2'h0 && lvpSession && wpWord[LVP_BIT]) begin
      progNew[LVP_BIT] = 1'b1;
    end
    stWrEn   = stReady && (progWrEn || (doWrite && busOk));
    stWrIdx  = progWrEn ? progWrIndex : awCode[1:0];
    stWrData = progWrEn ? progNew : busNew;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wpWord <= WP_MASK;
      cpWord <= CP_MASK;
      rpWord <= RP_MASK;
    end else if (state == ST_LOAD1) begin
      wpWord <= storeRd;
    end else if (state == ST_LOAD2) begin
      cpWord <= storeRd;
    end else if (state == ST_LOAD3) begin
      rpWord <= storeRd;
    end else if (stWrEn) begin
      case (stWrIdx)
        2'h0:    wpWord <= stWrData;
        2'h1:    cpWord <= stWrData;
        2'h2:    rpWord <= stWrData;
        default: wpWord <= wpWord;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddrQ <= 24'h000000;
      wDataQ  <= 16'h0000;
      wStrbQ  <= 2'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld  <= 1'b1;
        awAddrQ <= awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld  <= 1'b1;
        wDataQ <= wdata[15:0];
        wStrbQ <= wstrb[1:0];
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      awready <= stReady && !awHeld && !(awvalid && awready) && !bvalid;
      wready  <= stReady && !wHeld && !(wvalid && wready) && !bvalid;
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= busOk ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= stReady && !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        case (decodeAddr(araddr))
          A_WP:    rdata <= {16'h0000, wpWord};
          A_CP:    rdata <= {16'h0000, cpWord};
          A_RP:    rdata <= {16'h0000, rpWord};
          A_REV:   rdata <= {16'h0000, FAMILY_CODE, MAJOR_REV, MINOR_REV};
          A_DEV:   rdata <= {16'h0000, PART_ID};
          default: begin
            rdata <= 32'h00000000;
            rresp <= RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Decoded protection outputs
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgReady          <= 1'b0;
      masterClearActive <= 1'b1;
      hvProgRequired    <= 1'b0;
      scannerRun        <= 1'b0;
      dataCodeProtected <= 1'b1;
      progCodeProtected <= 1'b1;
    end else begin
      cfgReady          <= stReady;
      masterClearActive <= wpWord[LVP_BIT] | masterClearPinEnable;
      hvProgRequired    <= !wpWord[LVP_BIT];
      scannerRun        <= wpWord[SCAN_BIT] && !scannerModuleDisable;
      // Held protected until the words are loaded
      dataCodeProtected <= !stReady || !cpWord[CPD_BIT];
      progCodeProtected <= !stReady || !cpWord[CP_BIT];
    end
  end

  // Nothing is granted until the words are loaded
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      memWrGrant <= 1'b0;
      memWrDeny  <= 1'b0;
      tblRdGrant <= 1'b0;
      tblRdDeny  <= 1'b0;
    end else begin
      memWrGrant <= memWrReq && stReady && wrAllowed(memWrRegion, wpWord);
      memWrDeny  <= memWrReq && !(stReady && wrAllowed(memWrRegion, wpWord));
      tblRdGrant <= tblRdReq && stReady && rdAllowed(tblRdTarget, tblRdSource, rpWord);
      tblRdDeny  <= tblRdReq && !(stReady && rdAllowed(tblRdTarget, tblRdSource, rpWord));
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_devRead;
    arvalid && arready && decodeAddr(araddr) == A_DEV;
  endsequence
  sequence s_revRead;
    arvalid && arready && decodeAddr(araddr) == A_REV;
  endsequence

  property p_lvpKept;
    stReady && lvpSession && wpWord[LVP_BIT] |=> wpWord[LVP_BIT];
  endproperty
  a_lvpKept: assert property (p_lvpKept) else $error("LOW_VOLT_PROG_ENABLE bit cleared in session");

  property p_mclrOnly;
    wpWord[LVP_BIT] |=> masterClearActive && !hvProgRequired;
  endproperty
  a_mclrOnly: assert property (p_mclrOnly) else $error("Pin not master clear");

  property p_scanGate;
    !wpWord[SCAN_BIT] || scannerModuleDisable |=> !scannerRun;
  endproperty
  a_scanGate: assert property (p_scanGate) else $error("Scanner runs while gated");

  property p_eeBlock;
    memWrReq && memWrRegion == RG_EEPROM && !wpWord[EE_BIT] |=> memWrDeny && !memWrGrant;
  endproperty
  a_eeBlock: assert property (p_eeBlock) else $error("EEPROM write not blocked");

  property p_bootBlock;
    memWrReq && memWrRegion == RG_BOOT && !wpWord[BOOT_BIT] |=> !memWrGrant;
  endproperty
  a_bootBlock: assert property (p_bootBlock) else $error("Boot write not blocked");

  property p_cfgLocked;
    doWrite && !wpWord[CFG_BIT] |=> bvalid && bresp == RESP_SLVERR && $stable(rpWord);
  endproperty
  a_cfgLocked: assert property (p_cfgLocked) else $error("Config write not refused");

  property p_blockWr;
    memWrReq && stReady && memWrRegion[2] |=> memWrGrant == $past(wpWord[memWrRegion[1:0]]);
  endproperty
  a_blockWr: assert property (p_blockWr) else $error("Block write gate wrong");

  property p_codeProt;
    stReady ##1 stReady |-> dataCodeProtected == !$past(cpWord[CPD_BIT])
      && progCodeProtected == !$past(cpWord[CP_BIT]);
  endproperty
  a_codeProt: assert property (p_codeProt) else $error("Code protect wrong");

  property p_tblRead;
    tblRdReq && stReady && tblRdTarget != tblRdSource && tblRdTarget == RG_BOOT
      && !rpWord[BTR_BIT] |=> tblRdDeny;
  endproperty
  a_tblRead: assert property (p_tblRead) else $error("Boot table read allowed");

  property p_idRead;
    s_devRead |=> rvalid && rdata[15:0] == PART_ID ##1 1'b1;
  endproperty
  a_idRead: assert property (p_idRead) else $error("Part identifier wrong");

  property p_revRead;
    s_revRead |=> rvalid && rdata[15:FAM_LSB] == FAMILY_CODE
      && rdata[FAM_LSB-1:MAJ_LSB] == MAJOR_REV && rdata[MAJ_LSB-1:0] == MINOR_REV;
  endproperty
  a_revRead: assert property (p_revRead) else $error("Revision word wrong");

  property p_noEarlyGrant;
    !stReady |=> !memWrGrant && !tblRdGrant;
  endproperty
  a_noEarlyGrant: assert property (p_noEarlyGrant) else $error("Grant before load");
endmodule
`default_nettype wire

/* File: bench/prog_port_model.sv */
/*
  Model of the external programmer port of the protection block.
  Assumes the bench pulses go for one cycle per word to be written.
*/
`default_nettype none
module prog_port_model (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [1:0]  idx,
  input  wire logic [15:0] data,
  input  wire logic        hvProgRequired,
  output logic             progWrEn,
  output logic      [1:0]  progWrIndex,
  output logic      [15:0] progWrData,
  output logic             hvApplied
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    progWrEn = 1'b0;
    progWrIndex = 2'h0;
    progWrData = 16'h0000;
    hvApplied = 1'b0;
  end
  always @(posedge ref_clk) begin
    progWrEn    <= go;
    // Idle bus alternates the last word and its complement each cycle
    progWrIndex <= go ? idx : ~progWrIndex;
    progWrData  <= go ? data : ~progWrData;
    hvApplied   <= go & hvProgRequired;
  end
endmodule
`default_nettype wire

/* File: bench/tb_nvm_protection_config.sv */
/*
  Self-checking bench for nvm_protection_config.
  Assumes the package and the programmer model are compiled first.
*/
`default_nettype none
module tb_nvm_protection_config;
  import nvm_protect_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [23:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [2:0] awprot = 0, arprot = 0;
  logic [1:0] bresp, rresp, idx = 0, progWrIndex;
  logic lvpSession = 0, masterClearPinEnable = 0, scannerModuleDisable = 0;
  logic memWrReq = 0, tblRdReq = 0, go = 0, progWrEn, hvApplied, cfgReady;
  logic [15:0] data = 0, progWrData;
  region_t memWrRegion = RG_OTHER, tblRdTarget = RG_OTHER, tblRdSource = RG_OTHER;
  logic masterClearActive, hvProgRequired, scannerRun, dataCodeProtected;
  logic progCodeProtected, memWrGrant, memWrDeny, tblRdGrant, tblRdDeny;
  int mismatches = 0, checksDone = 0, seed = 32'h7b80;
  always #12.5 ref_clk = ~ref_clk;
  nvm_protection_config uut (.ref_clk, .reset_n, .awvalid, .awready, .awaddr, .awprot,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .lvpSession, .progWrEn,
    .progWrIndex, .progWrData, .masterClearPinEnable, .scannerModuleDisable,
    .memWrReq, .memWrRegion, .tblRdReq, .tblRdTarget, .tblRdSource, .cfgReady,
    .masterClearActive, .hvProgRequired, .scannerRun, .dataCodeProtected,
    .progCodeProtected, .memWrGrant, .memWrDeny, .tblRdGrant, .tblRdDeny);
  prog_port_model partner (.ref_clk, .go, .idx, .data, .hvProgRequired, .progWrEn,
    .progWrIndex, .progWrData, .hvApplied);
  // ********************************
  // Report and compare
  // ********************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    $display("mismatch timeout expected answer seen none");
    close_out();
  endtask
  task automatic chkW(input string nm, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkB(input string nm, input logic e, input logic g);
    chkW(nm, {15'h0, e}, {15'h0, g});
  endtask
  // ********************************
  // Bus and request drivers
  // ********************************
  task automatic axiWr(input logic [23:0] a, input logic [15:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0, d};
    wstrb <= 4'hf;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) hang();
  endtask
  task automatic axiRd(input logic [23:0] a, output logic [15:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata[15:0];
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) hang();
  endtask
  task automatic req(input logic [2:0] w, input logic [2:0] t, input logic [2:0] s,
                     input logic eW, input logic eR);
    @(posedge ref_clk);
    memWrReq <= 1'b1;
    memWrRegion <= region_t'(w);
    tblRdReq <= 1'b1;
    tblRdTarget <= region_t'(t);
    tblRdSource <= region_t'(s);
    @(posedge ref_clk);
    memWrReq <= 1'b0;
    tblRdReq <= 1'b0;
    @(posedge ref_clk);
    chkB("memWrGrant", eW, memWrGrant);
    chkB("memWrDeny", !eW, memWrDeny);
    chkB("tblRdGrant", eR, tblRdGrant);
    chkB("tblRdDeny", !eR, tblRdDeny);
  endtask
  function automatic logic wrOk(input logic [15:0] wp, input logic [2:0] g);
    case (g)
      3'h0: wrOk = wp[EE_BIT];
      3'h1: wrOk = wp[BOOT_BIT];
      3'h2: wrOk = wp[CFG_BIT];
      3'h3: wrOk = 1'b1;
      default: wrOk = wp[g[1:0]];
    endcase
  endfunction
  function automatic logic rdOk(input logic [15:0] rp, input logic [2:0] t, input logic [2:0] s);
    if (t == s || t == 3'h0 || t == 3'h2 || t == 3'h3) rdOk = 1'b1;
    else if (t == 3'h1) rdOk = rp[BTR_BIT];
    else rdOk = rp[t[1:0]];
  endfunction
  initial begin
    logic [15:0] wp, rp, v, d;
    logic [1:0] r;
    logic [31:0] x, y;
    int i, j, n;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    req(3'h3, 3'h3, 3'h3, 1'b0, 1'b0);
    for (n = 0; n < 50 && cfgReady !== 1'b1; n++) @(posedge ref_clk);
    if (n == 50) hang();
    axiRd({IDX_WP, 2'h0}, d, r); chkW("wp", WP_MASK, d);
    axiRd({IDX_CP, 2'h0}, d, r); chkW("cp", CP_MASK, d);
    axiRd({IDX_RP, 2'h0}, d, r); chkW("rp", RP_MASK, d);
    axiRd({IDX_REV, 2'h0}, d, r); chkW("rev", 16'h6042, d);
    axiRd({IDX_DEV, 2'h0}, d, r); chkW("dev", 16'h5a3c, d);
    axiRd(24'h000100, d, r); chkW("badResp", RESP_SLVERR, r);
    chkB("master_clear_pin", 1'b1, masterClearActive);
    chkB("dcp", 1'b0, dataCodeProtected);
    chkB("pcp", 1'b0, progCodeProtected);
    lvpSession <= 1'b1;
    axiWr({IDX_WP, 2'h0}, 16'h170f, r);
    axiRd({IDX_WP, 2'h0}, d, r); chkW("wpLvp", WP_MASK, d);
    $display("test reset done");
    wp = WP_MASK;
    for (i = 0; i < 24; i++) begin
      x = $random(seed);
      lvpSession <= x[16];
      masterClearPinEnable <= x[17];
      scannerModuleDisable <= x[18];
      v = (x[15:0] | 16'h0100) & WP_MASK;
      if (x[16] && wp[LVP_BIT]) v[LVP_BIT] = 1'b1;
      wp = v;
      axiWr({IDX_WP, 2'h0}, x[15:0] | 16'h0100, r); chkW("wpResp", RESP_OKAY, r);
      axiRd({IDX_WP, 2'h0}, d, r); chkW("wp", wp, d);
      rp = x[31:16] & RP_MASK;
      axiWr({IDX_RP, 2'h0}, x[31:16], r);
      axiRd({IDX_RP, 2'h0}, d, r); chkW("rp", rp, d);
      repeat (2) @(posedge ref_clk);
      chkB("master_clear_pin", wp[LVP_BIT] | x[17], masterClearActive);
      chkB("hv", !wp[LVP_BIT], hvProgRequired);
      chkB("scan", wp[SCAN_BIT] & !x[18], scannerRun);
      for (j = 0; j < 8; j++) begin
        y = $random(seed);
        req(j[2:0], j[2:0], y[2:0], wrOk(wp, j[2:0]), rdOk(rp, j[2:0], y[2:0]));
      end
    end
    lvpSession <= 1'b0;
    $display("test random done");
    axiWr({IDX_CP, 2'h0}, 16'h0000, r); chkW("cpResp", RESP_SLVERR, r);
    axiWr({IDX_REV, 2'h0}, 16'h0000, r); chkW("revResp", RESP_SLVERR, r);
    axiRd({IDX_CP, 2'h0}, d, r); chkW("cpKeep", CP_MASK, d);
    @(posedge ref_clk);
    go <= 1'b1;
    idx <= 2'h1;
    data <= 16'h0000;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chkB("dcp", 1'b1, dataCodeProtected);
    chkB("pcp", 1'b1, progCodeProtected);
    axiWr({IDX_WP, 2'h0}, 16'h3600, r);
    axiWr({IDX_WP, 2'h0}, 16'hffff, r); chkW("lockResp", RESP_SLVERR, r);
    axiRd({IDX_WP, 2'h0}, d, r); chkW("wpLock", 16'h3600, d);
    req(3'h2, 3'h2, 3'h2, 1'b0, 1'b1);
    req(3'h4, 3'h1, 3'h5, 1'b0, rp[BTR_BIT]);
    $display("test lock done");
    close_out();
  end
endmodule
`default_nettype wire
